// *** ilpc_pkg.sv ***
package ilpc_pkg;

  // Register map (byte addresses on the AHB-Lite port)
  localparam logic [31:0] CFG_ADDR = 32'h0000_00C8;
  localparam logic [31:0] STAT_ADDR = 32'h0000_00CC;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CFG_WMASK = 8'h70;
  localparam int CFG_LES_BIT = 6;
  localparam int CFG_ESB_BIT = 5;
  localparam int CFG_GEN_BIT = 4;

  // Status register field positions
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_MODE_LSB = 3;
  localparam int STAT_NMI_BIT = 5;
  localparam int STAT_PA_BIT = 6;
  localparam int STAT_PBC_BIT = 7;
  localparam int STAT_TMR_BIT = 8;
  localparam int STAT_ADC_BIT = 9;

  // Vector addresses, first byte of each pair
  localparam logic [11:0] VEC_RESET = 12'hFFE;
  localparam logic [11:0] VEC_NMI = 12'hFFC;
  localparam logic [11:0] VEC_PA = 12'hFF6;
  localparam logic [11:0] VEC_PBC = 12'hFF4;
  localparam logic [11:0] VEC_TMR = 12'hFF2;
  localparam logic [11:0] VEC_ADC = 12'hFF0;

  // Timing, in CPU cycles and input clock periods
  localparam int CLK_PER_CPU = 13;
  localparam int RESP_MIN_CPU = 6;
  localparam int RESP_MAX_CPU = 11;
  localparam logic [11:0] RESP_CLKS = 12'(RESP_MIN_CPU * CLK_PER_CPU);
  localparam logic [11:0] STOP_RESTART_CLKS = 12'h800;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_WAIT = 3'b001,
    ST_STOP = 3'b010,
    ST_RESTART = 3'b011,
    ST_RESPOND = 3'b100
  } ilpc_state_type;

  typedef enum logic [1:0] {
    MD_NORMAL = 2'b00,
    MD_IRQ = 2'b01,
    MD_NMI = 2'b10
  } ilpc_mode_type;

endpackage

// *** ilpc_edge_latch.sv ***
`timescale 1ns/1ps
module ilpc_edge_latch (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Request line and control
  input wire logic line,
  input wire logic rise_sel,
  input wire logic clear,
  // Pending request
  output logic req_q
);
  logic prev_q;
  logic set_edge;

  assign set_edge = rise_sel ? (line & ~prev_q) : (~line & prev_q);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= line;
    end
  end

  // Single pending request; an edge in the clearing cycle still sets
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      req_q <= 1'b0;
    end else if (set_edge) begin
      req_q <= 1'b1;
    end else if (clear) begin
      req_q <= 1'b0;
    end
  end
endmodule

// *** ilpc_delay.sv ***
`timescale 1ns/1ps
module ilpc_delay #(
  parameter int W = 12
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Start with a load value
  input wire logic start,
  input wire logic [W-1:0] load_val,
  // One-cycle pulse after load_val edges
  output logic done_q
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (start) begin
      cnt_q <= load_val;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= !start && (cnt_q == W'(1));
    end
  end
endmodule

// *** ilpc_core.sv ***
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
module ilpc_core #(
  parameter int VEC2_PINS = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // External request pins
  input wire logic nmi_pin,
  input wire logic port_a_pin,
  input wire logic [VEC2_PINS-1:0] vec2_pins,
  input wire logic [VEC2_PINS-1:0] vec2_pin_irq_en,
  // Peripheral requests (flag and local enable already combined)
  input wire logic timer_req,
  input wire logic adc_req,
  // Core sequencer
  input wire logic instr_boundary,
  input wire logic return_from_interrupt,
  input wire logic wait_exec,
  input wire logic stop_exec,
  input wire logic cfg_clear_busy,
  output logic push_pc,
  output logic vector_load,
  output logic [11:0] vector_addr,
  output logic [1:0] flag_sel,
  output logic pc_restore,
  output logic isr_ready,
  output logic cpu_halt,
  // Clock and watchdog control
  input wire logic watchdog_active,
  input wire logic external_stop_control_option,
  output logic osc_enable,
  output logic watchdog_freeze
);
  import ilpc_pkg::*;

  function automatic logic word_hit(input logic [31:0] a, input logic [31:0] t);
    word_hit = (a[31:2] == t[31:2]);
  endfunction

  ilpc_state_type state_q, state_d;
  ilpc_mode_type mode_q, prev_mode_q;
  logic [7:0] cfg_q;
  logic [1:0] nmi_s, pa_s;
  logic [VEC2_PINS-1:0] v2_m, v2_s;
  logic nmi_line, pa_line, v2_line;
  logic nmi_req, pa_latch, pbc_req, pa_req;
  logic vec1_level_select, vec2_edge_polarity, gen;
  logic nmi_ok, mask_ok, any_mask, take, take_nmi;
  logic clr_nmi, clr_pa, clr_pbc;
  logic wake_wait, wake_stop, stop_as_wait;
  logic [11:0] vec_d;
  logic dly_start, dly_done;
  logic [11:0] dly_load;
  logic wr_pend_q;
  logic [31:0] addr_q;
  logic [31:0] status;

  assign vec1_level_select = cfg_q[CFG_LES_BIT];
  assign vec2_edge_polarity = cfg_q[CFG_ESB_BIT];
  assign gen = cfg_q[CFG_GEN_BIT];

  // Pin synchronisers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      nmi_s <= 2'h3;
      pa_s <= 2'h3;
      v2_m <= '1;
      v2_s <= '1;
    end else begin
      nmi_s <= {nmi_s[0], nmi_pin};
      pa_s <= {pa_s[0], port_a_pin};
      v2_m <= vec2_pins;
      v2_s <= v2_m;
    end
  end

  assign nmi_line = nmi_s[1];
  assign pa_line = pa_s[1];
  // Pins not set for interrupt read as pulled up; toggling the enable of a low
  // pin moves the shared line just like a pin edge
  assign v2_line = &(v2_s | ~vec2_pin_irq_en);

  ilpc_edge_latch u_nmi (
    .clk_sys(clk_sys),
    .rst(rst),
    .line(nmi_line),
    .rise_sel(1'b0),
    .clear(clr_nmi),
    .req_q(nmi_req)
  );

  ilpc_edge_latch u_pa (
    .clk_sys(clk_sys),
    .rst(rst),
    .line(pa_line),
    .rise_sel(1'b0),
    .clear(clr_pa),
    .req_q(pa_latch)
  );

  ilpc_edge_latch u_pbc (
    .clk_sys(clk_sys),
    .rst(rst),
    .line(v2_line),
    .rise_sel(vec2_edge_polarity),
    .clear(clr_pbc),
    .req_q(pbc_req)
  );

  // Level mode keeps nothing: the low pin is seen at instruction boundaries
  assign pa_req = vec1_level_select ? ~pa_line : pa_latch;

  // Selection at an instruction boundary
  assign any_mask = pa_req | pbc_req | timer_req | adc_req;
  assign nmi_ok = nmi_req && (mode_q != MD_NMI);
  assign mask_ok = gen && (mode_q == MD_NORMAL) && any_mask;
  assign take = (state_q == ST_RUN) && instr_boundary && (nmi_ok || mask_ok);
  assign take_nmi = nmi_ok;

  always_comb begin
    vec_d = VEC_ADC;
    if (take_nmi) begin
      vec_d = VEC_NMI;
    end else if (pa_req) begin
      vec_d = VEC_PA;
    end else if (pbc_req) begin
      vec_d = VEC_PBC;
    end else if (timer_req) begin
      vec_d = VEC_TMR;
    end
  end

  assign clr_nmi = take && take_nmi;
  assign clr_pa = (take && !take_nmi && vec_d == VEC_PA) || vec1_level_select;
  assign clr_pbc = take && !take_nmi && vec_d == VEC_PBC;

  // Wake conditions; a cleared global enable blocks every wake source
  assign wake_wait = gen && (nmi_req || any_mask);
  assign wake_stop = gen && (nmi_req || pa_req || pbc_req || timer_req);
  assign stop_as_wait = watchdog_active && !(external_stop_control_option && nmi_line);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (take) begin
          state_d = ST_RESPOND;
        end else if (wait_exec) begin
          state_d = ST_WAIT;
        end else if (stop_exec) begin
          state_d = stop_as_wait ? ST_WAIT : ST_STOP;
        end
      end
      ST_WAIT: begin
        if (wake_wait) begin
          state_d = ST_RUN;
        end
      end
      ST_STOP: begin
        if (wake_stop) begin
          state_d = ST_RESTART;
        end
      end
      ST_RESTART: begin
        if (dly_done) begin
          state_d = ST_RUN;
        end
      end
      ST_RESPOND: begin
        if (dly_done) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  assign dly_start = take || (state_q == ST_STOP && state_d == ST_RESTART);
  assign dly_load = take ? RESP_CLKS : STOP_RESTART_CLKS;

  ilpc_delay #(
    .W(12)
  ) u_delay (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(dly_start),
    .load_val(dly_load),
    .done_q(dly_done)
  );

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= ST_RUN;
      cpu_halt <= 1'b0;
      osc_enable <= 1'b1;
      watchdog_freeze <= 1'b0;
    end else begin
      state_q <= state_d;
      cpu_halt <= (state_d == ST_WAIT) || (state_d == ST_STOP) || (state_d == ST_RESTART);
      osc_enable <= (state_d != ST_STOP);
      watchdog_freeze <= (state_d == ST_STOP) && watchdog_active;
    end
  end

  // Mode tracking; one saved level lets a non-maskable nest over a maskable
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_q <= MD_NORMAL;
      prev_mode_q <= MD_NORMAL;
    end else if (take) begin
      if (take_nmi) begin
        prev_mode_q <= mode_q;
        mode_q <= MD_NMI;
      end else begin
        mode_q <= MD_IRQ;
      end
    end else if (return_from_interrupt && state_q == ST_RUN) begin
      mode_q <= (mode_q == MD_NMI) ? prev_mode_q : MD_NORMAL;
      prev_mode_q <= MD_NORMAL;
    end
  end

  // Sequencer strobes: push first, vector load one cycle later
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      push_pc <= 1'b0;
      vector_load <= 1'b0;
      vector_addr <= VEC_RESET;
      flag_sel <= MD_NORMAL;
      pc_restore <= 1'b0;
      isr_ready <= 1'b0;
    end else begin
      push_pc <= take;
      vector_load <= push_pc;
      pc_restore <= return_from_interrupt && state_q == ST_RUN && mode_q != MD_NORMAL;
      isr_ready <= (state_q == ST_RESPOND) && dly_done;
      if (take) begin
        vector_addr <= vec_d;
      end
      if (take) begin
        if (take_nmi) begin
          flag_sel <= MD_NMI;
        end else if (cfg_clear_busy && mode_q == MD_NORMAL) begin
          flag_sel <= MD_NORMAL;
        end else begin
          flag_sel <= MD_IRQ;
        end
      end else if (return_from_interrupt && state_q == ST_RUN) begin
        flag_sel <= (mode_q == MD_NMI) ? prev_mode_q : MD_NORMAL;
      end
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  always_comb begin
    status = 32'h0000_0000;
    status[STAT_STATE_LSB +: 3] = state_q;
    status[STAT_MODE_LSB +: 2] = mode_q;
    status[STAT_NMI_BIT] = nmi_req;
    status[STAT_PA_BIT] = pa_req;
    status[STAT_PBC_BIT] = pbc_req;
    status[STAT_TMR_BIT] = timer_req;
    status[STAT_ADC_BIT] = adc_req;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      addr_q <= 32'h0000_0000;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (hready) begin
      wr_pend_q <= hsel && htrans[1] && hwrite;
      addr_q <= haddr;
      // The config register is write-only and reads as zero
      hrdata <= (hsel && htrans[1] && !hwrite && word_hit(haddr, STAT_ADDR)) ?
                status : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_q <= CFG_RESET;
    end else if (wr_pend_q && word_hit(addr_q, CFG_ADDR)) begin
      cfg_q <= hwdata[7:0] & CFG_WMASK;
    end
  end

  // Checks
  // Take edge to first sample of isr_ready: push, load, then 78 clocks of response
  localparam int RESP_WAIT = 80;
  logic [11:0] rst_cnt_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rst_cnt_q <= 12'h000;
    end else if (state_q == ST_RESTART) begin
      rst_cnt_q <= rst_cnt_q + 12'h001;
    end else begin
      rst_cnt_q <= 12'h000;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_push_then_load: assert property (take |=> push_pc ##1 vector_load)
    else $error("vector loaded without prior push");
  chk_nmi_vector: assert property (
    take && take_nmi |=> vector_addr == VEC_NMI && flag_sel == MD_NMI)
    else $error("non-maskable vector or flags wrong");
  chk_irq_flags: assert property (
    take && !take_nmi && !cfg_clear_busy |=> flag_sel == MD_IRQ)
    else $error("interrupt flag pair not selected");
  chk_ldi_flags: assert property (
    take && !take_nmi && cfg_clear_busy |=> flag_sel == MD_NORMAL)
    else $error("flag pair switched during config clear");
  chk_no_nesting: assert property (take && !take_nmi |-> mode_q == MD_NORMAL && gen)
    else $error("maskable taken while servicing or disabled");
  chk_latch_clear: assert property (take && take_nmi && !$fell(nmi_line) |=> !nmi_req)
    else $error("request latch not cleared");
  chk_resp_time: assert property (take |-> ##RESP_WAIT isr_ready)
    else $error("response time wrong");
  chk_restart_len: assert property (
    state_q == ST_RESTART && state_d == ST_RUN |-> rst_cnt_q == STOP_RESTART_CLKS)
    else $error("restart delay wrong");
  chk_adc_nostop: assert property (
    state_q == ST_STOP && !nmi_req && !pa_req && !pbc_req && !timer_req
    |=> state_q == ST_STOP)
    else $error("left stop without a stop wake source");
  chk_gen_wake: assert property (state_q == ST_WAIT && !gen |=> state_q == ST_WAIT)
    else $error("woke with global enable clear");
  chk_stop_wdg: assert property (
    state_q == ST_RUN && !take && !wait_exec && stop_exec && stop_as_wait
    |=> state_q == ST_WAIT ##1 osc_enable)
    else $error("stop not demoted to wait");
  chk_return_from_interrupt_mode: assert property (
    return_from_interrupt && state_q == ST_RUN && mode_q == MD_IRQ
    |=> mode_q == MD_NORMAL && pc_restore)
    else $error("return did not restore mode");

  cov_nmi_take: cover property (take && take_nmi);
  cov_wait_wake: cover property (state_q == ST_WAIT ##1 state_q == ST_RUN);
  cov_stop_restart: cover property (state_q == ST_RESTART && state_d == ST_RUN);
  cov_ldi_case: cover property (take && !take_nmi && cfg_clear_busy);
endmodule

// *** ilpc_seq_model.sv ***
`timescale 1ns/1ps
module ilpc_seq_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Core status
  input wire logic cpu_halt,
  input wire logic isr_ready,
  // Sequencer strobes
  output logic instr_boundary,
  output logic return_from_interrupt
);
  logic [1:0] step_q;
  logic [3:0] ret_q;

  // One instruction ends every four clocks while the core runs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      step_q <= 2'h0;
      instr_boundary <= 1'b0;
    end else begin
      step_q <= cpu_halt ? 2'h0 : step_q + 2'h1;
      instr_boundary <= !cpu_halt && step_q == 2'h3;
    end
  end

  // Routine body runs a few clocks, then returns
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ret_q <= 4'h0;
      return_from_interrupt <= 1'b0;
    end else begin
      ret_q <= isr_ready ? 4'h9 : (ret_q != 4'h0 ? ret_q - 4'h1 : 4'h0);
      return_from_interrupt <= ret_q == 4'h1;
    end
  end
endmodule

// *** ilpc_core_tb.sv ***
`timescale 1ns/1ps
module ilpc_core_tb;
  import ilpc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0, flag_sel;
  logic [2:0] hsize = 3'h2;
  logic [7:0] vec2_pins = 8'hFF, vec2_pin_irq_en = 8'h00;
  logic nmi_pin = 1'b1, port_a_pin = 1'b1, timer_req = 1'b0, adc_req = 1'b0;
  logic wait_exec = 1'b0, stop_exec = 1'b0, cfg_clear_busy = 1'b0;
  logic watchdog_active = 1'b0, external_stop_control_option = 1'b0;
  logic hreadyout, hresp, instr_boundary, return_from_interrupt, push_pc;
  logic vector_load, pc_restore, isr_ready, cpu_halt, osc_enable, watchdog_freeze;
  logic [11:0] vector_addr;
  logic [13:0] exp_q[$];
  int n_mismatch = 0, n_compared = 0, cyc = 0, t_push = 0, k, p;

  always #50 clk_sys = ~clk_sys;

  ilpc_core #(.VEC2_PINS(8)) dut (.clk_sys(clk_sys), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .nmi_pin(nmi_pin), .port_a_pin(port_a_pin), .vec2_pins(vec2_pins),
    .vec2_pin_irq_en(vec2_pin_irq_en), .timer_req(timer_req), .adc_req(adc_req),
    .instr_boundary(instr_boundary), .return_from_interrupt(return_from_interrupt),
    .wait_exec(wait_exec), .stop_exec(stop_exec), .cfg_clear_busy(cfg_clear_busy),
    .push_pc(push_pc), .vector_load(vector_load), .vector_addr(vector_addr),
    .flag_sel(flag_sel), .pc_restore(pc_restore), .isr_ready(isr_ready),
    .cpu_halt(cpu_halt), .watchdog_active(watchdog_active),
    .external_stop_control_option(external_stop_control_option),
    .osc_enable(osc_enable), .watchdog_freeze(watchdog_freeze));

  ilpc_seq_model seq (.clk_sys(clk_sys), .rst(rst), .cpu_halt(cpu_halt),
    .isr_ready(isr_ready), .instr_boundary(instr_boundary),
    .return_from_interrupt(return_from_interrupt));

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_vec(input logic [13:0] got, input logic [13:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: vector/flags got %h expected %h", $time, got, exp);
    end
  endtask

  task results;
    $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Single AHB-Lite word transfer; hready is the slave's own hreadyout
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
  endtask

  task cfg(input logic [7:0] v);
    bus(1'b1, CFG_ADDR, {24'h0, v});
  endtask

  task expect_vec(input logic [11:0] v, input logic [1:0] f);
    exp_q.push_back({v, f});
  endtask

  task drain(input string name);
    k = 0;
    while (exp_q.size() != 0 && k < 3000) begin
      @(posedge clk_sys);
      k++;
    end
    tick(100);
    cmp_val(32'(exp_q.size()), 32'h0, "pending vectors");
    $display("test %s done", name);
  endtask

  // Every vector load is matched against the oldest expectation
  always @(posedge clk_sys) begin
    cyc++;
    if (!rst && vector_load === 1'b1) t_push = cyc;
    if (!rst && vector_load === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("wrong value at %0t: unexpected vector %h", $time, vector_addr);
      end else begin
        cmp_vec({vector_addr, flag_sel}, exp_q.pop_front());
      end
    end
    if (!rst && isr_ready === 1'b1) begin
      cmp_val(32'(cyc - t_push), 32'(RESP_CLKS), "response time");
      // The routine clears the peripheral flag it serves
      if (vector_addr === VEC_TMR) timer_req <= 1'b0;
      if (vector_addr === VEC_ADC) adc_req <= 1'b0;
    end
  end

  initial begin
    tick(20000);
    n_mismatch++;
    $display("wrong value at %0t: timeout", $time);
    results;
  end

  initial begin
    k = $urandom(32'h1A0AE6EE);
    p = $urandom % 8;
    tick(16);
    rst <= 1'b0;
    @(posedge clk_sys);
    cmp_val({20'h0, vector_addr}, {20'h0, VEC_RESET}, "reset vector");
    cmp_val({cpu_halt, osc_enable}, 32'h1, "run after reset");
    bus(1'b0, CFG_ADDR, 32'h0);
    cmp_val(rd, 32'h0, "config read");
    bus(1'b0, 32'h0000_0040, 32'h0);
    cmp_val(rd, 32'h0, "unmapped read");
    bus(1'b0, STAT_ADDR, 32'h0);
    cmp_val(rd, 32'h0, "status idle");
    cmp_val({hreadyout, hresp}, 32'h2, "bus response");
    $display("test reset done");
    vec2_pin_irq_en <= 8'h01 << p;
    @(posedge clk_sys);
    timer_req <= 1'b1;
    adc_req <= 1'b1;
    port_a_pin <= 1'b0;
    vec2_pins[p] <= 1'b0;
    tick(30);
    expect_vec(VEC_PA, MD_IRQ);
    expect_vec(VEC_PBC, MD_IRQ);
    expect_vec(VEC_TMR, MD_IRQ);
    expect_vec(VEC_ADC, MD_IRQ);
    cfg(8'h10);
    drain("priority");
    port_a_pin <= 1'b1;
    vec2_pins <= 8'hFF;
    vec2_pin_irq_en <= 8'h00;
    cfg_clear_busy <= 1'b1;
    timer_req <= 1'b1;
    expect_vec(VEC_TMR, MD_NORMAL);
    tick(12);
    cfg_clear_busy <= 1'b0;
    drain("clear load");
    vec2_pins[p] <= 1'b0;
    tick(4);
    expect_vec(VEC_PBC, MD_IRQ);
    vec2_pin_irq_en[p] <= 1'b1;
    drain("enable low pin");
    cfg(8'h30);
    expect_vec(VEC_PBC, MD_IRQ);
    vec2_pin_irq_en <= 8'h00;
    drain("disable low pin");
    vec2_pins <= 8'hFF;
    cfg(8'h00);
    wait_exec <= 1'b1;
    @(posedge clk_sys);
    wait_exec <= 1'b0;
    nmi_pin <= 1'b0;
    tick(40);
    cmp_val({cpu_halt, osc_enable}, 32'h3, "wait holds");
    expect_vec(VEC_NMI, MD_NMI);
    cfg(8'h10);
    drain("wait nmi");
    nmi_pin <= 1'b1;
    stop_exec <= 1'b1;
    @(posedge clk_sys);
    stop_exec <= 1'b0;
    adc_req <= 1'b1;
    tick(30);
    cmp_val({cpu_halt, osc_enable}, 32'h2, "stop holds");
    expect_vec(VEC_TMR, MD_IRQ);
    expect_vec(VEC_ADC, MD_IRQ);
    timer_req <= 1'b1;
    k = 0;
    @(posedge clk_sys);
    while (cpu_halt === 1'b1 && k < 3000) begin
      @(posedge clk_sys);
      k++;
    end
    cmp_val(32'(k >= 2048 && k <= 2054), 32'h1, "restart delay");
    drain("stop");
    watchdog_active <= 1'b1;
    stop_exec <= 1'b1;
    @(posedge clk_sys);
    stop_exec <= 1'b0;
    tick(3);
    cmp_val({cpu_halt, osc_enable, watchdog_freeze}, 32'h6, "stop as wait");
    expect_vec(VEC_ADC, MD_IRQ);
    adc_req <= 1'b1;
    drain("watchdog wait");
    external_stop_control_option <= 1'b1;
    stop_exec <= 1'b1;
    @(posedge clk_sys);
    stop_exec <= 1'b0;
    tick(3);
    cmp_val({cpu_halt, osc_enable, watchdog_freeze}, 32'h5, "frozen stop");
    expect_vec(VEC_TMR, MD_IRQ);
    timer_req <= 1'b1;
    drain("watchdog stop");
    results;
  end
endmodule
